// [logic/spf_framer.sv]
`default_nettype none
module spf_framer import spf_pkg::*; #(
	parameter logic BIG_ENDIAN = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// configuration
	input wire logic [7:0] sync_third,
	// transmit command
	input wire logic tx_start,
	input wire logic [7:0] tx_type,
	input wire logic [15:0] tx_data_len,
	output logic tx_busy,
	output logic tx_done,
	output logic tx_refused,
	// transmit data in
	input wire logic tx_in_valid,
	input wire logic [7:0] tx_in_data,
	output logic tx_in_ready,
	// link out
	output logic link_tx_valid,
	output logic [7:0] link_tx_data,
	input wire logic link_tx_ready,
	// link in
	input wire logic link_rx_valid,
	input wire logic [7:0] link_rx_data,
	// received payload
	output logic rx_frame_start,
	output logic [15:0] rx_length,
	output logic [7:0] rx_type,
	output logic rx_data_valid,
	output logic [7:0] rx_data,
	output logic [15:0] rx_data_index,
	output logic rx_frame_ok,
	output logic rx_err_checksum,
	output logic rx_err_short,
	// field extraction
	input wire logic [2:0] fld_kind,
	input wire logic [3:0] fld_acd_len,
	input wire logic [15:0] fld_base,
	input wire logic [15:0] fld_index,
	output logic [31:0] fld_value,
	output logic fld_valid,
	output logic fld_format_error,
	// program entry decode
	input wire logic [15:0] prog_base,
	output var spf_prog_t prog_kind,
	output logic prog_valid,
	output logic prog_empty,
	output logic [15:0] prog_layout_len
);
	////////////////////////////////////////////////////////////////////////////////
	// transmit data fifo
	spf_stream_if #(.WIDTH(SPF_BYTE_W)) tx_fill ();
	spf_stream_if #(.WIDTH(SPF_BYTE_W)) tx_drain ();

	assign tx_fill.valid = tx_in_valid;
	assign tx_fill.data = tx_in_data;
	assign tx_in_ready = tx_fill.ready;

	spf_fifo #(.WIDTH(SPF_BYTE_W), .DEPTH(SPF_FIFO_DEPTH)) u_tx_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.fill(tx_fill.snk),
		.drain(tx_drain.src)
	);

	////////////////////////////////////////////////////////////////////////////////
	// transmit framing
	spf_tx_state_t tx_state_q;
	logic [15:0] tx_total_q;
	logic [15:0] tx_left_q;
	logic [7:0] tx_type_q;
	logic [7:0] tx_sync2_q;
	logic [7:0] tx_sum_q;
	logic out_valid_q;
	logic [7:0] out_data_q;
	logic tx_done_q;
	logic tx_refused_q;
	logic load_ok;
	logic tx_accept;
	logic tx_emit;
	logic [7:0] tx_byte;

	// the output byte is a register; a new byte loads when it is empty or being taken
	assign load_ok = !out_valid_q || link_tx_ready;
	assign tx_accept = tx_start && (tx_state_q == SPF_TX_IDLE) && (tx_data_len <= SPF_MAX_DATA);
	assign tx_drain.ready = (tx_state_q == SPF_TX_DATA) && load_ok;

	always_comb begin
		tx_byte = 8'h00;
		tx_emit = 1'b0;
		unique case (tx_state_q)
			SPF_TX_IDLE: begin
				tx_emit = 1'b0;
			end
			SPF_TX_SYNC0: begin
				tx_byte = SPF_SYNC_B0;
				tx_emit = load_ok;
			end
			SPF_TX_SYNC1: begin
				tx_byte = SPF_SYNC_B1;
				tx_emit = load_ok;
			end
			SPF_TX_SYNC2: begin
				tx_byte = tx_sync2_q;
				tx_emit = load_ok;
			end
			SPF_TX_LEN0: begin
				tx_byte = BIG_ENDIAN ? tx_total_q[15:8] : tx_total_q[7:0];
				tx_emit = load_ok;
			end
			SPF_TX_LEN1: begin
				tx_byte = BIG_ENDIAN ? tx_total_q[7:0] : tx_total_q[15:8];
				tx_emit = load_ok;
			end
			SPF_TX_TYPE: begin
				tx_byte = tx_type_q;
				tx_emit = load_ok;
			end
			SPF_TX_DATA: begin
				tx_byte = tx_drain.data;
				tx_emit = load_ok && tx_drain.valid;
			end
			SPF_TX_CSUM: begin
				tx_byte = tx_sum_q;
				tx_emit = load_ok;
			end
			default: begin
				tx_emit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_state_q <= SPF_TX_IDLE;
		end else begin
			unique case (tx_state_q)
				SPF_TX_IDLE: begin
					if (tx_accept) begin
						tx_state_q <= SPF_TX_SYNC0;
					end
				end
				SPF_TX_SYNC0: if (tx_emit) tx_state_q <= SPF_TX_SYNC1;
				SPF_TX_SYNC1: if (tx_emit) tx_state_q <= SPF_TX_SYNC2;
				SPF_TX_SYNC2: if (tx_emit) tx_state_q <= SPF_TX_LEN0;
				SPF_TX_LEN0: if (tx_emit) tx_state_q <= SPF_TX_LEN1;
				SPF_TX_LEN1: if (tx_emit) tx_state_q <= SPF_TX_TYPE;
				SPF_TX_TYPE: begin
					if (tx_emit) begin
						tx_state_q <= (tx_left_q == 16'h0000) ? SPF_TX_CSUM : SPF_TX_DATA;
					end
				end
				SPF_TX_DATA: begin
					if (tx_emit && (tx_left_q == 16'h0001)) begin
						tx_state_q <= SPF_TX_CSUM;
					end
				end
				SPF_TX_CSUM: if (tx_emit) tx_state_q <= SPF_TX_IDLE;
				default: tx_state_q <= SPF_TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_total_q <= 16'h0000;
			tx_left_q <= 16'h0000;
			tx_type_q <= 8'h00;
			tx_sync2_q <= SPF_SYNC_B2_DEF;
		end else if (tx_accept) begin
			tx_total_q <= tx_data_len + SPF_MIN_LEN;
			tx_left_q <= tx_data_len;
			tx_type_q <= tx_type;
			tx_sync2_q <= sync_third;
		end else if (tx_emit && (tx_state_q == SPF_TX_DATA)) begin
			tx_left_q <= tx_left_q - 16'h0001;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_sum_q <= 8'h00;
		end else if (tx_accept) begin
			tx_sum_q <= 8'h00;
		end else if (tx_emit && (tx_state_q != SPF_TX_CSUM)) begin
			tx_sum_q <= tx_sum_q ^ tx_byte;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			out_valid_q <= 1'b0;
			out_data_q <= 8'h00;
		end else if (tx_emit) begin
			out_valid_q <= 1'b1;
			out_data_q <= tx_byte;
		end else if (link_tx_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_done_q <= 1'b0;
			tx_refused_q <= 1'b0;
		end else begin
			tx_done_q <= tx_emit && (tx_state_q == SPF_TX_CSUM);
			tx_refused_q <= tx_start && !tx_accept;
		end
	end

	assign link_tx_valid = out_valid_q;
	assign link_tx_data = out_data_q;
	assign tx_busy = (tx_state_q != SPF_TX_IDLE);
	assign tx_done = tx_done_q;
	assign tx_refused = tx_refused_q;

	////////////////////////////////////////////////////////////////////////////////
	// receive unframing
	spf_rx_state_t rx_state_q;
	logic [15:0] rx_pos_q;
	logic [15:0] rx_len_q;
	logic [7:0] rx_len_first_q;
	logic [7:0] rx_type_q;
	logic [7:0] rx_sum_q;
	logic [15:0] rx_len_now;
	logic [15:0] rx_dofs;
	logic sync_done;
	logic in_data;
	logic csum_good;
	logic csum_bad;
	logic short_bad;

	assign rx_len_now = BIG_ENDIAN ? {rx_len_first_q, link_rx_data} : {link_rx_data, rx_len_first_q};
	assign rx_dofs = rx_pos_q - SPF_DATA_OFS;
	assign sync_done = link_rx_valid && (rx_state_q == SPF_RX_HUNT2) && (link_rx_data == sync_third);
	assign in_data = link_rx_valid && (rx_state_q == SPF_RX_DATA);
	// xor over every byte including the checksum itself comes out zero
	assign csum_good = link_rx_valid && (rx_state_q == SPF_RX_CSUM) && ((rx_sum_q ^ link_rx_data) == 8'h00);
	assign csum_bad = link_rx_valid && (rx_state_q == SPF_RX_CSUM) && ((rx_sum_q ^ link_rx_data) != 8'h00);
	assign short_bad = link_rx_valid && (rx_state_q == SPF_RX_LEN1) && (rx_len_now < SPF_MIN_LEN);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_state_q <= SPF_RX_HUNT0;
		end else if (link_rx_valid) begin
			unique case (rx_state_q)
				SPF_RX_HUNT0: begin
					if (link_rx_data == SPF_SYNC_B0) rx_state_q <= SPF_RX_HUNT1;
				end
				SPF_RX_HUNT1: begin
					if (link_rx_data == SPF_SYNC_B1) rx_state_q <= SPF_RX_HUNT2;
					else if (link_rx_data != SPF_SYNC_B0) rx_state_q <= SPF_RX_HUNT0;
				end
				SPF_RX_HUNT2: begin
					if (sync_done) rx_state_q <= SPF_RX_LEN0;
					else if (link_rx_data == SPF_SYNC_B0) rx_state_q <= SPF_RX_HUNT1;
					else rx_state_q <= SPF_RX_HUNT0;
				end
				SPF_RX_LEN0: rx_state_q <= SPF_RX_LEN1;
				SPF_RX_LEN1: rx_state_q <= short_bad ? SPF_RX_HUNT0 : SPF_RX_TYPE;
				SPF_RX_TYPE: rx_state_q <= (rx_len_q == SPF_MIN_LEN) ? SPF_RX_CSUM : SPF_RX_DATA;
				SPF_RX_DATA: begin
					if (rx_pos_q == (rx_len_q - SPF_LAST_DATA_BACK)) rx_state_q <= SPF_RX_CSUM;
				end
				SPF_RX_CSUM: rx_state_q <= SPF_RX_HUNT0;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_pos_q <= 16'h0000;
			rx_sum_q <= 8'h00;
		end else if (sync_done) begin
			rx_pos_q <= SPF_LEN_OFS;
			rx_sum_q <= SPF_SYNC_B0 ^ SPF_SYNC_B1 ^ link_rx_data;
		end else if (link_rx_valid) begin
			rx_pos_q <= rx_pos_q + 16'h0001;
			rx_sum_q <= rx_sum_q ^ link_rx_data;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_len_first_q <= 8'h00;
			rx_len_q <= 16'h0000;
			rx_type_q <= 8'h00;
		end else if (link_rx_valid) begin
			if (rx_state_q == SPF_RX_LEN0) rx_len_first_q <= link_rx_data;
			if (rx_state_q == SPF_RX_LEN1) rx_len_q <= rx_len_now;
			if (rx_state_q == SPF_RX_TYPE) rx_type_q <= link_rx_data;
		end
	end

	// payload bytes go out as they arrive; a later checksum failure cannot recall them
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_data_valid <= 1'b0;
			rx_data <= 8'h00;
			rx_data_index <= 16'h0000;
			rx_frame_start <= 1'b0;
			rx_frame_ok <= 1'b0;
			rx_err_checksum <= 1'b0;
			rx_err_short <= 1'b0;
		end else begin
			rx_data_valid <= in_data;
			if (in_data) begin
				rx_data <= link_rx_data;
				rx_data_index <= rx_dofs;
			end
			rx_frame_start <= sync_done;
			rx_frame_ok <= csum_good;
			rx_err_checksum <= csum_bad;
			rx_err_short <= short_bad;
		end
	end

	assign rx_length = rx_len_q;
	assign rx_type = rx_type_q;

	////////////////////////////////////////////////////////////////////////////////
	// field extraction from the data section
	spf_kind_t fld_kind_q;
	logic [15:0] fld_ofs_q;
	logic [3:0] fld_len_q;
	logic [3:0] fld_cnt_q;
	logic [31:0] fld_acc_q;
	logic fld_neg_q;
	logic fld_seen_q;
	logic fld_bad_q;
	logic fld_hit;
	logic fld_acd;

	assign fld_hit = in_data && (rx_dofs >= fld_ofs_q) && (fld_cnt_q < fld_len_q);
	assign fld_acd = (fld_kind_q == SPF_K_ACD_U) || (fld_kind_q == SPF_K_ACD_S);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fld_kind_q <= SPF_K_U8;
			fld_ofs_q <= 16'h0000;
			fld_len_q <= SPF_LEN_B8;
		end else if (sync_done) begin
			fld_kind_q <= spf_kind_t'(fld_kind);
			fld_ofs_q <= spf_field_ofs(fld_base, fld_index, spf_elem_len(spf_kind_t'(fld_kind), fld_acd_len));
			fld_len_q <= spf_elem_len(spf_kind_t'(fld_kind), fld_acd_len);
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fld_cnt_q <= 4'h0;
			fld_acc_q <= 32'h0000_0000;
			fld_neg_q <= 1'b0;
			fld_seen_q <= 1'b0;
			fld_bad_q <= 1'b0;
		end else if (sync_done) begin
			fld_cnt_q <= 4'h0;
			fld_acc_q <= 32'h0000_0000;
			fld_neg_q <= 1'b0;
			fld_seen_q <= 1'b0;
			fld_bad_q <= 1'b0;
		end else if (fld_hit) begin
			fld_cnt_q <= fld_cnt_q + 4'h1;
			if (!fld_acd) begin
				if (BIG_ENDIAN) fld_acc_q <= {fld_acc_q[23:0], link_rx_data};
				else fld_acc_q[{fld_cnt_q[1:0], 3'b000} +: 8] <= link_rx_data;
			end else if (spf_is_digit(link_rx_data)) begin
				fld_acc_q <= spf_mul10(fld_acc_q) + {28'h000_0000, link_rx_data[3:0]};
				fld_seen_q <= 1'b1;
			end else if ((link_rx_data == SPF_ASCII_SPACE) && !fld_seen_q) begin
				fld_seen_q <= 1'b0;
			end else if ((fld_cnt_q == 4'h0) && (fld_kind_q == SPF_K_ACD_S) &&
				((link_rx_data == SPF_ASCII_MINUS) || (link_rx_data == SPF_ASCII_PLUS))) begin
				fld_neg_q <= (link_rx_data == SPF_ASCII_MINUS);
			end else begin
				fld_bad_q <= 1'b1;
			end
		end
	end

	// results hold the last good frame; a frame that ends early leaves fld_valid low
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fld_value <= 32'h0000_0000;
			fld_valid <= 1'b0;
			fld_format_error <= 1'b0;
		end else if (csum_good) begin
			fld_value <= fld_acd ? (fld_neg_q ? -fld_acc_q : fld_acc_q) : spf_sign_ext(fld_acc_q, fld_kind_q);
			fld_valid <= (fld_cnt_q == fld_len_q) && !fld_bad_q;
			fld_format_error <= fld_bad_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// program entry decode
	logic [15:0] prog_base_q;
	logic [7:0] prog_op_q;
	logic prog_seen_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prog_base_q <= 16'h0000;
			prog_op_q <= SPF_OP_EMPTY;
			prog_seen_q <= 1'b0;
		end else if (sync_done) begin
			prog_base_q <= prog_base;
			prog_seen_q <= 1'b0;
		end else if (in_data && (rx_dofs == prog_base_q)) begin
			prog_op_q <= link_rx_data;
			prog_seen_q <= 1'b1;
		end
	end

	// the layout length is known only after the selector is decoded
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prog_kind <= SPF_PROG_EMPTY;
			prog_valid <= 1'b0;
			prog_empty <= 1'b0;
			prog_layout_len <= SPF_LAYOUT_UNKNOWN;
		end else if (csum_good) begin
			prog_kind <= spf_op_decode(prog_op_q);
			prog_valid <= prog_seen_q;
			prog_empty <= prog_seen_q && (prog_op_q == SPF_OP_EMPTY);
			prog_layout_len <= (prog_op_q == SPF_OP_EMPTY) ? SPF_EMPTY_ENTRY_LEN : SPF_LAYOUT_UNKNOWN;
		end
	end
endmodule : spf_framer
`default_nettype wire

// [logic/spf_pkg.sv]
`default_nettype none
package spf_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// frame layout
	localparam logic [7:0] SPF_SYNC_B0 = 8'hfe;
	localparam logic [7:0] SPF_SYNC_B1 = 8'hfa;
	localparam logic [7:0] SPF_SYNC_B2_DEF = 8'h31;
	localparam logic [7:0] SPF_SYNC_B2_ALT_A = 8'h30;
	localparam logic [7:0] SPF_SYNC_B2_ALT_B = 8'h32;
	localparam logic [15:0] SPF_LEN_OFS = 16'h0003;
	localparam logic [15:0] SPF_TYPE_OFS = 16'h0005;
	localparam logic [15:0] SPF_DATA_OFS = 16'h0006;
	localparam logic [15:0] SPF_MIN_LEN = 16'h0007;
	localparam logic [15:0] SPF_MAX_DATA = 16'hfff8;
	localparam logic [15:0] SPF_LAST_DATA_BACK = 16'h0002;
	localparam int SPF_BYTE_W = 8;
	localparam int SPF_FIFO_DEPTH = 16;
	////////////////////////////////////////////////////////////////////////////////
	// primitive fields
	localparam logic [3:0] SPF_LEN_B8 = 4'h1;
	localparam logic [3:0] SPF_LEN_B16 = 4'h2;
	localparam logic [3:0] SPF_LEN_B32 = 4'h4;
	localparam logic [3:0] SPF_ACD_MAX_LEN = 4'hf;
	localparam logic [7:0] SPF_ASCII_ZERO = 8'h30;
	localparam logic [7:0] SPF_ASCII_NINE = 8'h39;
	localparam logic [7:0] SPF_ASCII_SPACE = 8'h20;
	localparam logic [7:0] SPF_ASCII_MINUS = 8'h2d;
	localparam logic [7:0] SPF_ASCII_PLUS = 8'h2b;
	////////////////////////////////////////////////////////////////////////////////
	// program entries
	localparam logic [7:0] SPF_OP_EMPTY = 8'h00;
	localparam logic [7:0] SPF_OP_SOUND = 8'h01;
	localparam logic [7:0] SPF_OP_TEST = 8'h02;
	localparam logic [7:0] SPF_OP_EQUAL = 8'h03;
	localparam logic [15:0] SPF_EMPTY_ENTRY_LEN = 16'h0001;
	localparam logic [15:0] SPF_LAYOUT_UNKNOWN = 16'h0000;

	typedef enum logic [2:0] {
		SPF_K_U8 = 3'b000, SPF_K_S8 = 3'b001, SPF_K_U16 = 3'b010, SPF_K_S16 = 3'b011,
		SPF_K_U32 = 3'b100, SPF_K_S32 = 3'b101, SPF_K_ACD_U = 3'b110, SPF_K_ACD_S = 3'b111
	} spf_kind_t;
	typedef enum logic [2:0] {
		SPF_PROG_EMPTY = 3'b000, SPF_PROG_SOUND = 3'b001, SPF_PROG_TEST = 3'b010,
		SPF_PROG_EQUAL = 3'b011, SPF_PROG_UNKNOWN = 3'b100
	} spf_prog_t;
	typedef enum logic [3:0] {
		SPF_TX_IDLE = 4'h0, SPF_TX_SYNC0 = 4'h1, SPF_TX_SYNC1 = 4'h2, SPF_TX_SYNC2 = 4'h3,
		SPF_TX_LEN0 = 4'h4, SPF_TX_LEN1 = 4'h5, SPF_TX_TYPE = 4'h6, SPF_TX_DATA = 4'h7,
		SPF_TX_CSUM = 4'h8
	} spf_tx_state_t;
	typedef enum logic [2:0] {
		SPF_RX_HUNT0 = 3'b000, SPF_RX_HUNT1 = 3'b001, SPF_RX_HUNT2 = 3'b010, SPF_RX_LEN0 = 3'b011,
		SPF_RX_LEN1 = 3'b100, SPF_RX_TYPE = 3'b101, SPF_RX_DATA = 3'b110, SPF_RX_CSUM = 3'b111
	} spf_rx_state_t;

	function automatic logic [3:0] spf_elem_len(input spf_kind_t kind, input logic [3:0] acd_len);
		unique case (kind)
			SPF_K_U8, SPF_K_S8: return SPF_LEN_B8;
			SPF_K_U16, SPF_K_S16: return SPF_LEN_B16;
			SPF_K_U32, SPF_K_S32: return SPF_LEN_B32;
			SPF_K_ACD_U, SPF_K_ACD_S: return (acd_len == 4'h0) ? SPF_LEN_B8 : acd_len;
		endcase
	endfunction : spf_elem_len

	// element i of an array, or a packed structure member, sits at base + i * len
	function automatic logic [15:0] spf_field_ofs(input logic [15:0] base, input logic [15:0] index,
		input logic [3:0] elen);
		return base + index * {12'h000, elen};
	endfunction : spf_field_ofs

	function automatic logic [31:0] spf_sign_ext(input logic [31:0] raw, input spf_kind_t kind);
		unique case (kind)
			SPF_K_S8: return {{24{raw[7]}}, raw[7:0]};
			SPF_K_S16: return {{16{raw[15]}}, raw[15:0]};
			default: return raw;
		endcase
	endfunction : spf_sign_ext

	function automatic logic spf_is_digit(input logic [7:0] b);
		return (b >= SPF_ASCII_ZERO) && (b <= SPF_ASCII_NINE);
	endfunction : spf_is_digit

	function automatic logic [31:0] spf_mul10(input logic [31:0] a);
		return {a[28:0], 3'b000} + {a[30:0], 1'b0};
	endfunction : spf_mul10

	function automatic spf_prog_t spf_op_decode(input logic [7:0] op);
		unique case (op)
			SPF_OP_EMPTY: return SPF_PROG_EMPTY;
			SPF_OP_SOUND: return SPF_PROG_SOUND;
			SPF_OP_TEST: return SPF_PROG_TEST;
			SPF_OP_EQUAL: return SPF_PROG_EQUAL;
			default: return SPF_PROG_UNKNOWN;
		endcase
	endfunction : spf_op_decode
endpackage : spf_pkg
`default_nettype wire

// [logic/spf_stream_if.sv]
`default_nettype none
interface spf_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : spf_stream_if
`default_nettype wire

// [logic/spf_fifo.sv]
`default_nettype none
// depth must be a power of two so the pointers wrap by themselves
module spf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// streams
	spf_stream_if.snk fill,
	spf_stream_if.src drain
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW:0] EMPTY_CNT = '0;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign fill.ready = (count_q != FULL_CNT);
	assign drain.valid = (count_q != EMPTY_CNT);
	assign drain.data = mem_q[rd_ptr_q];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= fill.data;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			count_q <= '0;
		end else if (push && !pop) begin
			count_q <= count_q + 1'b1;
		end else if (pop && !push) begin
			count_q <= count_q - 1'b1;
		end
	end
endmodule : spf_fifo
`default_nettype wire

// [testbench/spf_framer_props.sv]
`default_nettype none
module spf_framer_props import spf_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// transmit side
	input wire logic [7:0] sync_third,
	input wire logic tx_start,
	input wire logic [15:0] tx_data_len,
	input wire logic tx_busy,
	input wire logic tx_done,
	input wire logic tx_refused,
	input wire logic link_tx_valid,
	input wire logic [7:0] link_tx_data,
	input wire logic link_tx_ready,
	// receive side
	input wire logic link_rx_valid,
	input wire logic [7:0] link_rx_data,
	input wire logic rx_frame_start,
	input wire logic rx_data_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_frame_ok,
	input wire logic rx_err_checksum,
	input wire logic prog_valid,
	input wire logic prog_empty,
	input wire spf_prog_t prog_kind,
	input wire logic [15:0] prog_layout_len
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_tx_sync_first: assert property (tx_start && !tx_busy && tx_data_len <= 16'hfff8 |=>
		tx_busy ##1 link_tx_valid && link_tx_data == 8'hfe) else $error("frame did not open with sync");
	chk_tx_len_refused: assert property (tx_start && !tx_busy && tx_data_len > 16'hfff8 |=>
		tx_refused && !tx_busy) else $error("oversize frame accepted");
	chk_tx_byte_held: assert property (link_tx_valid && !link_tx_ready |=>
		link_tx_valid && $stable(link_tx_data)) else $error("link byte changed while stalled");
	chk_done_on_sum: assert property (tx_done |-> link_tx_valid && !tx_busy) else $error("done off checksum");
	chk_rx_sync_match: assert property (rx_frame_start |->
		$past(link_rx_valid) && $past(link_rx_data) == sync_third) else $error("frame start without sync");
	chk_rx_data_copy: assert property (rx_data_valid |->
		$past(link_rx_valid) && rx_data == $past(link_rx_data)) else $error("data byte not from link");
	chk_rx_verdict: assert property (rx_frame_ok |-> $past(link_rx_valid) && !rx_err_checksum)
		else $error("verdict not after a byte");
	chk_empty_entry: assert property (prog_valid && prog_empty |->
		prog_kind == SPF_PROG_EMPTY && prog_layout_len == 16'h0001) else $error("empty entry misdecoded");
	cover property (tx_done);
	cover property (rx_frame_ok);
	cover property (rx_err_checksum);
endmodule : spf_framer_props
bind spf_framer spf_framer_props i_props (.*);
`default_nettype wire

// [testbench/spf_dev_model.sv]
`default_nettype none
module spf_dev_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// link both ways
	input wire logic [7:0] sync_third,
	output logic link_tx_ready,
	output logic link_rx_valid,
	output logic [7:0] link_rx_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] prog_tab [128];
	logic [1:0] stall_q;
	// one stall in four keeps the framer's hold logic busy
	always_ff @(negedge core_clk or posedge reset) begin
		if (reset) stall_q <= 2'h0;
		else stall_q <= stall_q + 2'h1;
	end
	assign link_tx_ready = stall_q != 2'h3;
	initial begin
		link_rx_valid = 1'b0;
		link_rx_data = 8'h00;
		foreach (prog_tab[i]) prog_tab[i] = 8'(i % 4);
	end
	function automatic void mk(input logic [7:0] t, input logic [7:0] d[$], output logic [7:0] f[$]);
		logic [15:0] n;
		logic [7:0] c;
		n = 16'(d.size() + 7);
		f = {8'hfe, 8'hfa, sync_third, n[7:0], n[15:8], t};
		f = {f, d};
		c = 8'h00;
		foreach (f[i]) c ^= f[i];
		f.push_back(c);
	endfunction : mk
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(negedge core_clk);
			link_rx_valid = 1'b1;
			link_rx_data = b[i];
		end
		@(negedge core_clk);
		link_rx_valid = 1'b0;
		link_rx_data = ~link_rx_data;
	endtask : send
	task automatic frame(input logic [7:0] t, input logic [7:0] d[$], input logic bad);
		logic [7:0] f[$];
		mk(t, d, f);
		f[f.size() - 1] ^= {7'h00, bad};
		send(f);
	endtask : frame
	// an empty entry is never run; the report carries the index that was asked for
	task automatic run(input logic [6:0] idx, input logic [7:0] report_type);
		if (prog_tab[idx] == 8'h00) frame(report_type, {8'(idx)}, 1'b0);
	endtask : run
endmodule : spf_dev_model
`default_nettype wire

// [testbench/sounder_packet_framer_tb.sv]
`default_nettype none
module sounder_packet_framer_tb import spf_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, reset, tx_start, tx_in_valid, tx_busy, tx_done, tx_refused, tx_in_ready, link_tx_valid;
	logic link_tx_ready, link_rx_valid, rx_frame_start, rx_data_valid, rx_frame_ok, rx_err_checksum, rx_err_short;
	logic fld_valid, fld_format_error, prog_valid, prog_empty;
	logic [7:0] sync_third, tx_type, tx_in_data, link_tx_data, link_rx_data, rx_type, rx_data;
	logic [15:0] tx_data_len, fld_base, fld_index, prog_base, rx_length, rx_data_index, prog_layout_len;
	logic [2:0] fld_kind;
	logic [3:0] fld_acd_len;
	logic [31:0] fld_value, v;
	spf_prog_t prog_kind;
	int fail_count = 0, n_checks = 0, seed = 18, k;
	logic [7:0] tx_q[$], rx_q[$], d[$], f[$];
	logic [81:0] ev_q[$];
	spf_framer i_dut (.*);
	spf_dev_model i_dev (.*);
	always #10 core_clk = ~core_clk;
	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (e !== g) begin
			fail_count++;
			$display("[ERR] %0t byte exp %h got %h", $time, e, g);
		end
	endtask : cmp_byte
	task automatic cmp_rec(input logic [81:0] e, input logic [81:0] g);
		if (!e[81]) g[78:0] = e[78:0];
		n_checks++;
		if (e !== g) begin
			fail_count++;
			$display("[ERR] %0t frame exp %h got %h", $time, e, g);
		end
	endtask : cmp_rec
	task automatic results;
		if (fail_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	task automatic settle;
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge core_clk);
			if (!tx_busy && tx_q.size() == 0 && rx_q.size() == 0 && ev_q.size() == 0) break;
		end
		if (i == 3000) begin
			fail_count++;
			$display("[ERR] %0t stuck", $time);
			results();
		end
	endtask : settle
	always @(posedge core_clk) begin
		if (link_tx_valid && link_tx_ready) cmp_byte(tx_q.pop_front(), link_tx_data);
		if (rx_data_valid) cmp_byte(rx_q.pop_front(), rx_data);
		if (rx_frame_ok || rx_err_checksum || rx_err_short) cmp_rec(ev_q.pop_front(), {rx_frame_ok,
			rx_err_checksum, rx_err_short, prog_kind, prog_empty, fld_valid, fld_value,
			rx_type, rx_length, prog_valid, fld_format_error, prog_layout_len});
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{core_clk, reset, tx_start, tx_in_valid, tx_in_data, tx_type, tx_data_len, prog_base} = {2'b01, 50'h0};
		{sync_third, fld_kind, fld_acd_len, fld_base, fld_index} = {SPF_SYNC_B2_DEF, 7'h04, 32'h0001_0001};
		repeat (3) @(posedge core_clk);
		@(negedge core_clk) reset = 1'b0;
		// fill the buffer until it refuses, send it, then an empty frame
		for (int n = 16; n >= 0; n -= 16) begin
			d = {};
			repeat (n) begin
				@(negedge core_clk);
				tx_in_valid = 1'b1;
				tx_in_data = 8'($random(seed));
				d.push_back(tx_in_data);
			end
			// one more byte offered to a full buffer must be held off
			if (n > 0) begin
				@(negedge core_clk);
				tx_in_data = 8'($random(seed));
				cmp_byte(8'h00, {7'h00, tx_in_ready});
				@(negedge core_clk);
			end
			tx_in_valid = 1'b0;
			tx_type = 8'($random(seed));
			tx_data_len = 16'(n);
			i_dev.mk(tx_type, d, f);
			tx_q = f;
			tx_start = 1'b1;
			repeat (2) @(negedge core_clk);
			tx_start = 1'b0;
			cmp_byte(8'h01, {7'h00, tx_refused});
			settle();
		end
		tx_data_len = 16'hfff9;
		tx_start = 1'b1;
		@(negedge core_clk) tx_start = 1'b0;
		cmp_byte(8'h01, {7'h00, tx_refused});
		// broken sync, corrupt sum and short length; hunting must resume after each
		i_dev.send({8'hfe, 8'hfa, 8'h00});
		rx_q.push_back(8'h01);
		ev_q.push_back({3'b010, 79'h0});
		i_dev.frame(8'h10, {8'h01}, 1'b1);
		ev_q.push_back({3'b001, 79'h0});
		i_dev.send({8'hfe, 8'hfa, 8'h31, 8'h05, 8'h00});
		settle();
		for (k = 0; k < 8; k++) begin
			d = {};
			repeat (12) d.push_back(8'($random(seed)));
			d[0] = i_dev.prog_tab[k];
			v = (k == 6) ? 32'h20303432 : 32'h2d303132;
			if (k > 5) for (int i = 0; i < 4; i++) d[5 + i] = v[31 - 8 * i -: 8];
			case (k)
				0: v = {24'h0, d[2]};
				1: v = {{24{d[2][7]}}, d[2]};
				2: v = {16'h0, d[4], d[3]};
				3: v = {{16{d[4][7]}}, d[4], d[3]};
				4, 5: v = {d[8], d[7], d[6], d[5]};
				6: v = 32'd42;
				default: v = 32'hfffffff4;
			endcase
			fld_kind = 3'(k);
			sync_third = (k == 6) ? SPF_SYNC_B2_ALT_A : (k == 7) ? SPF_SYNC_B2_ALT_B : SPF_SYNC_B2_DEF;
			ev_q.push_back({3'b100, 3'(k % 4), k % 4 == 0, 1'b1, v, 8'(k), SPF_MIN_LEN + 16'd12, 1'b1, 1'b0,
				(k % 4 == 0) ? SPF_EMPTY_ENTRY_LEN : SPF_LAYOUT_UNKNOWN});
			rx_q = {rx_q, d};
			i_dev.frame(8'(k), d, 1'b0);
			settle();
		end
		// asking the far side to run an empty entry draws an error report frame
		rx_q.push_back(8'h00);
		ev_q.push_back({3'b100, 3'd0, 1'b1, 1'b0, 32'h0, 8'he0, SPF_MIN_LEN + 16'd1, 1'b1, 1'b0,
			SPF_EMPTY_ENTRY_LEN});
		i_dev.run(7'd0, 8'he0);
		settle();
		results();
	end
endmodule : sounder_packet_framer_tb
`default_nettype wire
